// *** hdl/wdg_top.sv ***
// wdg_top: watchdog timer with timed unlock, safety levels and reset-cause flags, APB slave.
// assumes: the 128 kHz oscillator and the safety fuse arrive as asynchronous levels; restart,
// chip-reset events, global interrupt enable and vector-taken come from logic on clk.
`timescale 1ns/1ps
`default_nettype none

module wdg_top
  import wdg_pkg::*;
#(
  parameter int CNT_W = COUNT_W
) (
  input wire logic clk,
  input wire logic arst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // asynchronous sources
  input wire logic oscClk,
  input wire logic safetyLevelOption,
  // core side
  input wire logic restartPulse,
  input wire logic globalIrqEnable,
  input wire logic irqTaken,
  input wire logic powerupResetEvent,
  input wire logic brownoutResetEvent,
  input wire logic pinResetEvent,
  output logic timeoutIrq,
  output logic watchdogResetPulse,
  output logic safetyLevel2
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic irqFlag;
    logic irqEnable;
    logic unlock;
    logic [2:0] unlockCnt;
    logic timerEnable;
    logic [3:0] period;
    logic [3:0] cause;
    logic level2;
    logic [1:0] fuseWait;
    logic oscPrev;
    logic resetPulse;
    logic timeoutIrq;
  } wdg_top_s;

  wdg_top_s s;
  wdg_top_s next_s;

  logic oscSync;
  logic fuseSync;
  logic oscTick;
  logic expire;
  logic effEnable;
  logic running;
  logic chipReset;
  logic counterClear;
  logic xferDone;
  logic wrCtrl;
  logic wrCause;
  logic [7:0] wbyte;
  logic [7:0] ctrlView;
  logic [7:0] causeView;
  logic accessPhase;
  logic hitCtrl;
  logic hitCause;
  logic [1:0] actionMode;

  if (CNT_W < BASE_LOG2 + int'(PERIOD_MAX)) begin : g_bad_width
    $error("wdg_top: CNT_W too small for the longest period");
  end

  if (UNLOCK_CYCLES == 3'h0) begin : g_bad_unlock
    $error("wdg_top: unlock window must last at least one cycle");
  end

  // ****************************************
  // crossings
  // ****************************************
  wdg_level_sync #(
    .W(2)
  ) u_sync (
    .clk(clk),
    .arst_n(arst_n),
    .d({oscClk, safetyLevelOption}),
    .q({oscSync, fuseSync})
  );

  // one tick per oscillator rising edge, taken from the stable flop only
  // the oscillator is far slower than clk, so no edge is lost or seen twice
  assign oscTick = oscSync && !s.oscPrev;

  // ****************************************
  // period counter
  // ****************************************
  assign effEnable = s.timerEnable || s.level2;
  assign running = effEnable || s.irqEnable;
  assign chipReset = powerupResetEvent || brownoutResetEvent || pinResetEvent || s.resetPulse;
  assign counterClear = restartPulse || chipReset;

  wdg_timeout_counter #(
    .CNT_W(CNT_W)
  ) u_counter (
    .clk(clk),
    .arst_n(arst_n),
    .tick(oscTick),
    .clear(counterClear),
    .run(running),
    .sel(s.period),
    .expire(expire)
  );

  // ****************************************
  // bus decode
  // ****************************************
  // second access cycle answers; data and error are registered with pready
  assign accessPhase = psel && penable && !s.pready;
  assign xferDone = psel && penable && s.pready;
  assign hitCtrl = (paddr == ADDR_CTRL);
  assign hitCause = (paddr == ADDR_CAUSE);
  assign wrCtrl = xferDone && pwrite && hitCtrl;
  assign wrCause = xferDone && pwrite && hitCause;
  assign wbyte = pwdata[7:0];
  assign ctrlView = {s.irqFlag, s.irqEnable, s.period[3], s.unlock, effEnable, s.period[2:0]};
  // upper cause bits are not implemented and always read zero
  assign causeView = {4'h0, s.cause};
  // action on expiry is chosen by the pair {enable, irq enable}
  assign actionMode = {effEnable, s.irqEnable};

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    next_s = s;
    next_s.oscPrev = oscSync;
    next_s.resetPulse = 1'b0;

    // ****************************************
    // fuse strap
    // ****************************************
    // the synchroniser leaves reset at zero, so the level is followed for
    // three edges and then frozen
    if (s.fuseWait != 2'h3) begin
      next_s.level2 = fuseSync;
      next_s.fuseWait = s.fuseWait + 2'h1;
    end

    // ****************************************
    // bus answer
    // ****************************************
    // apb answer, data and error stand for the ready cycle only
    next_s.pready = accessPhase;
    next_s.pslverr = 1'b0;
    next_s.prdata = '0;
    if (accessPhase) begin
      next_s.pslverr = !(hitCtrl || hitCause);
      if (!pwrite && hitCtrl) begin
        next_s.prdata = {24'h000000, ctrlView};
      end else if (!pwrite && hitCause) begin
        next_s.prdata = {24'h000000, causeView};
      end
    end

    // ****************************************
    // unlock window
    // ****************************************
    // unlock window closes on its own
    // a window opened again while open restarts its count
    if (s.unlock) begin
      if (s.unlockCnt <= 3'h1) begin
        next_s.unlock = 1'b0;
        next_s.unlockCnt = 3'h0;
      end else begin
        next_s.unlockCnt = s.unlockCnt - 3'h1;
      end
    end

    // ****************************************
    // control writes
    // ****************************************
    // vector taken clears the flag before any new timeout sets it
    if (irqTaken) begin
      next_s.irqFlag = 1'b0;
    end

    if (wrCtrl) begin
      next_s.irqEnable = wbyte[CTRL_IRQ_EN];
      if (wbyte[CTRL_IRQ_FLAG]) begin
        next_s.irqFlag = 1'b0;
      end
      if (wbyte[CTRL_UNLOCK] && wbyte[CTRL_EN]) begin
        next_s.unlock = 1'b1;
        next_s.unlockCnt = UNLOCK_CYCLES;
      end else if (!wbyte[CTRL_UNLOCK]) begin
        next_s.unlock = 1'b0;
        next_s.unlockCnt = 3'h0;
        if (s.unlock) begin
          // reserved codes fall back to the longest legal period
          if ({wbyte[CTRL_PS3], wbyte[CTRL_PS_HI:0]} > PERIOD_MAX) begin
            next_s.period = PERIOD_MAX;
          end else begin
            next_s.period = {wbyte[CTRL_PS3], wbyte[CTRL_PS_HI:0]};
          end
        end
      end
      if (!s.level2) begin
        if (wbyte[CTRL_EN]) begin
          next_s.timerEnable = 1'b1;
        end else if (s.unlock && !wbyte[CTRL_UNLOCK]) begin
          next_s.timerEnable = 1'b0;
        end
      end
      // in level 2 the written enable value does not change timerEnable; it only gates opening the unlock window
    end

    // ****************************************
    // reset causes
    // ****************************************
    if (wrCause) begin
      // only zeros written clear; ones leave a flag as it is
      next_s.cause = s.cause & wbyte[3:0];
    end

    // chip reset returns control to initial values, except the enable, which is set again while the timeout cause flag stands
    if (chipReset) begin
      next_s.irqFlag = 1'b0;
      next_s.irqEnable = 1'b0;
      next_s.unlock = 1'b0;
      next_s.unlockCnt = 3'h0;
      next_s.timerEnable = 1'b0;
      next_s.period = 4'h0;
    end

    // reset causes: sets win over software clears in the same cycle
    if (powerupResetEvent) begin
      next_s.cause = CAUSE_POR_VALUE;
    end
    if (brownoutResetEvent) begin
      next_s.cause[CAUSE_BROWNOUT] = 1'b1;
    end
    if (pinResetEvent) begin
      next_s.cause[CAUSE_PIN] = 1'b1;
    end

    // ****************************************
    // timeout action
    // ****************************************
    // a pending reset pulse shadows a late expiry
    if (expire && !chipReset) begin
      unique case (actionMode)
        2'b00: begin
          // stopped: the counter is held clear, nothing to do
        end
        2'b01: begin
          next_s.irqFlag = 1'b1;
        end
        2'b10: begin
          next_s.resetPulse = 1'b1;
          next_s.cause[CAUSE_TIMEOUT] = 1'b1;
        end
        2'b11: begin
          // interrupt first; the next expiry resets unless software re-arms
          next_s.irqFlag = 1'b1;
          next_s.irqEnable = 1'b0;
        end
      endcase
    end

    if (!s.level2 && next_s.cause[CAUSE_TIMEOUT]) begin
      next_s.timerEnable = 1'b1;
    end

    // ****************************************
    // interrupt request
    // ****************************************
    // in mode 11 hardware drops irq enable on the timeout, so the request still
    // stands while enable is set and the flag is pending
    next_s.timeoutIrq = next_s.irqFlag && globalIrqEnable &&
                        (next_s.irqEnable || next_s.timerEnable || next_s.level2);
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s <= '0;
      s.cause <= CAUSE_POR_VALUE;
    end else begin
      s <= next_s;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign timeoutIrq = s.timeoutIrq;
  assign watchdogResetPulse = s.resetPulse;
  assign safetyLevel2 = s.level2;

endmodule : wdg_top

`default_nettype wire

// *** hdl/wdg_pkg.sv ***
// wdg_pkg: register map, field positions and timing counts of the watchdog supervisor.
// assumes: a 32-bit APB with 12-bit byte addresses; registers are 8 bits wide in the low lane.
package wdg_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] IDX_CTRL = 8'h21;
  localparam logic [7:0] IDX_CAUSE = 8'h22;
  localparam logic [11:0] ADDR_CTRL = {2'b00, IDX_CTRL, 2'b00};
  localparam logic [11:0] ADDR_CAUSE = {2'b00, IDX_CAUSE, 2'b00};

  // ****************************************
  // watchdog_control_status fields
  // ****************************************
  localparam int CTRL_IRQ_FLAG = 7;
  localparam int CTRL_IRQ_EN = 6;
  localparam int CTRL_PS3 = 5;
  localparam int CTRL_UNLOCK = 4;
  localparam int CTRL_EN = 3;
  localparam int CTRL_PS_HI = 2;

  // ****************************************
  // reset_cause_status fields
  // ****************************************
  localparam int CAUSE_TIMEOUT = 3;
  localparam int CAUSE_BROWNOUT = 2;
  localparam int CAUSE_PIN = 1;
  localparam int CAUSE_POWERUP = 0;
  localparam logic [3:0] CAUSE_POR_VALUE = 4'h1;

  // ****************************************
  // timing
  // ****************************************
  localparam int OSC_FREQ_KHZ = 128;
  localparam logic [2:0] UNLOCK_CYCLES = 3'h4;
  localparam logic [3:0] PERIOD_MAX = 4'h9;
  localparam int BASE_LOG2 = 11;
  localparam int COUNT_W = 20;

endpackage : wdg_pkg

// *** hdl/wdg_level_sync.sv ***
// wdg_level_sync: two-flop synchroniser for levels arriving from outside the clk domain.
// assumes: inputs change slowly compared with clk; only the second flop is visible.
`timescale 1ns/1ps
`default_nettype none

module wdg_level_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } wdg_sync_s;

  wdg_sync_s s;
  wdg_sync_s next_s;

  if (W < 1) begin : g_bad_width
    $error("wdg_level_sync: W must be at least 1");
  end

  always_comb begin
    next_s = s;
    next_s.meta = d;
    next_s.stable = s.meta;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign q = s.stable;

endmodule : wdg_level_sync

`default_nettype wire

// *** hdl/wdg_timeout_counter.sv ***
// wdg_timeout_counter: counts oscillator ticks and flags expiry of the selected period.
// assumes: tick is a one-cycle clk pulse per oscillator edge; sel is already a legal code.
`timescale 1ns/1ps
`default_nettype none

module wdg_timeout_counter
  import wdg_pkg::*;
#(
  parameter int CNT_W = COUNT_W
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic tick,
  input wire logic clear,
  input wire logic run,
  input wire logic [3:0] sel,
  output logic expire
);

  typedef struct packed {
    logic [CNT_W-1:0] count;
    logic expire;
  } wdg_cnt_s;

  wdg_cnt_s s;
  wdg_cnt_s next_s;
  logic [CNT_W-1:0] limit;

  if (CNT_W < BASE_LOG2 + int'(PERIOD_MAX)) begin : g_bad_width
    $error("wdg_timeout_counter: CNT_W too small for the longest period");
  end

  always_comb begin
    // doubling periods from 2K ticks: limit is a mask of ones
    limit = ~({CNT_W{1'b1}} << (BASE_LOG2 + int'(sel)));
    next_s = s;
    next_s.expire = 1'b0;
    if (clear || !run) begin
      next_s.count = '0;
    end else if (tick) begin
      if (s.count == limit) begin
        next_s.count = '0;
        next_s.expire = 1'b1;
      end else begin
        next_s.count = s.count + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign expire = s.expire;

endmodule : wdg_timeout_counter

`default_nettype wire

// *** tb/wdg_top_assertions.sv ***
// wdg_top_assertions: port-level properties of the watchdog supervisor.
// assumes: bound into every wdg_top instance; one clock domain.
`timescale 1ns/1ps
`default_nettype none
module wdg_top_assertions
  import wdg_pkg::*;
#(
  parameter int CNT_W = COUNT_W
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic restartPulse,
  input wire logic globalIrqEnable,
  input wire logic irqTaken,
  input wire logic timeoutIrq,
  input wire logic watchdogResetPulse,
  input wire logic safetyLevel2
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // ****************************************
  // properties
  // ****************************************
  sequence s_access;
    penable && !pready ##1 pready;
  endsequence
  sequence s_quiet;
    !watchdogResetPulse [*8];
  endsequence
  a_apb_wait: assert property (psel && !penable |=> s_access)
    else $error("pready not in second access cycle");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held");
  a_unmapped_err: assert property (pready && paddr != ADDR_CTRL && paddr != ADDR_CAUSE
    |-> pslverr && prdata == 32'h0) else $error("unmapped access not refused");
  a_cause_high: assert property (pready && !pwrite && paddr == ADDR_CAUSE |->
    prdata[7:4] == 4'h0 && !pslverr) else $error("cause upper bits set");
  a_level2_en: assert property (safetyLevel2 && pready && !pwrite && paddr == ADDR_CTRL
    |-> prdata[CTRL_EN]) else $error("enable reads zero in level 2");
  a_reset_single: assert property (watchdogResetPulse |=> !watchdogResetPulse)
    else $error("reset pulse longer than one cycle");
  a_irq_gate: assert property (!globalIrqEnable |=> !timeoutIrq)
    else $error("interrupt without global enable");
  a_taken_clear: assert property (irqTaken |-> ##2 !timeoutIrq)
    else $error("interrupt kept after vector taken");
  a_restart_hold: assert property (restartPulse |-> ##2 s_quiet)
    else $error("reset soon after restart");
endmodule : wdg_top_assertions
bind wdg_top wdg_top_assertions #(.CNT_W(CNT_W)) chk_u (.*);
`default_nettype wire

// *** tb/tb_top.sv ***
// tb_top: self-checking bench for wdg_top over APB and core-side pulses.
// assumes: oscillator modelled as a free-running wave of 8 clk cycles.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import wdg_pkg::*;
  logic clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0, oscClk = 0;
  logic safetyLevelOption = 0, restartPulse = 0, globalIrqEnable = 0, irqTaken = 0;
  logic powerupResetEvent = 0, brownoutResetEvent = 0, pinResetEvent = 0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, timeoutIrq, watchdogResetPulse, safetyLevel2;
  logic [3:0] c;
  logic [32:0] expQ[$];
  int err_total = 0, comparisons = 0;
  wdg_top dut_u (.*);
  initial forever #4 clk = ~clk;
  initial forever begin
    repeat (4) @(posedge clk);
    oscClk <= ~oscClk;
  end
  // ****************************************
  // drivers and checks
  // ****************************************
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  always @(posedge clk) begin
    if (psel && penable && pready && !pwrite && expQ.size() > 0) begin
      check({pslverr, prdata}, expQ.pop_front());
    end
  end
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'($urandom), d};
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1, a, d);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    expQ.push_back({a != ADDR_CTRL && a != ADDR_CAUSE, 24'h0, e});
    apb(0, a, 8'h0);
  endtask : rd
  task automatic idle(input int n);
    psel <= 0;
    penable <= 0;
    repeat (n) @(posedge clk);
  endtask : idle
  localparam int P_RESTART = 0, P_TAKEN = 1, P_POWERUP = 2, P_BROWNOUT = 3, P_PIN = 4;
  task automatic pulse(input int k);
    idle(0);
    restartPulse <= (k == P_RESTART);
    irqTaken <= (k == P_TAKEN);
    powerupResetEvent <= (k == P_POWERUP);
    brownoutResetEvent <= (k == P_BROWNOUT);
    pinResetEvent <= (k == P_PIN);
    @(posedge clk);
    restartPulse <= 0;
    irqTaken <= 0;
    powerupResetEvent <= 0;
    brownoutResetEvent <= 0;
    pinResetEvent <= 0;
    @(posedge clk);
  endtask : pulse
  // counts cycles to the event; 2048 ticks of 8 clk plus sync slack
  task automatic waitEv(input logic irq);
    int n;
    n = 0;
    while ((irq ? timeoutIrq : watchdogResetPulse) !== 1'b1 && n < 20000) begin
      @(posedge clk);
      n++;
    end
    check({32'h0, n >= 16000 && n < 16800}, 33'h1);
  endtask : waitEv
  task automatic results;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : results
  initial begin
    repeat (100000) @(posedge clk);
    err_total++;
    results();
  end
  // ****************************************
  // tests
  // ****************************************
  initial begin
    void'($urandom(32'h57bec57c));
    repeat (16) @(posedge clk);
    arst_n <= 1;
    idle(4);
    rd(ADDR_CAUSE, 8'h01);
    rd(ADDR_CTRL, 8'h00);
    rd(12'h090, 8'h00);
    wr(ADDR_CTRL, 8'h0b);
    rd(ADDR_CTRL, 8'h08);
    wr(ADDR_CTRL, 8'h00);
    rd(ADDR_CTRL, 8'h08);
    wr(ADDR_CTRL, 8'h18);
    idle(6);
    wr(ADDR_CTRL, 8'h00);
    rd(ADDR_CTRL, 8'h08);
    c = 4'ha + 4'($urandom % 6);
    wr(ADDR_CTRL, 8'h18);
    wr(ADDR_CTRL, {2'b00, c[3], 2'b00, c[2:0]});
    rd(ADDR_CTRL, 8'h21);
    $display("done: control access");
    wr(ADDR_CAUSE, 8'h00);
    rd(ADDR_CAUSE, 8'h00);
    pulse(P_BROWNOUT);
    pulse(P_PIN);
    rd(ADDR_CAUSE, 8'h06);
    wr(ADDR_CAUSE, 8'hf2);
    rd(ADDR_CAUSE, 8'h02);
    $display("done: reset causes");
    wr(ADDR_CTRL, 8'h18);
    wr(ADDR_CTRL, 8'h08);
    idle(1);
    waitEv(0);
    rd(ADDR_CAUSE, 8'h0a);
    wr(ADDR_CTRL, 8'h18);
    wr(ADDR_CTRL, 8'h00);
    rd(ADDR_CTRL, 8'h08);
    pulse(P_POWERUP);
    rd(ADDR_CAUSE, 8'h01);
    rd(ADDR_CTRL, 8'h00);
    $display("done: reset mode");
    globalIrqEnable <= 1;
    wr(ADDR_CTRL, 8'h40);
    idle(2000);
    pulse(P_RESTART);
    waitEv(1);
    globalIrqEnable <= 0;
    rd(ADDR_CTRL, 8'hc0);
    check({32'h0, timeoutIrq}, 33'h0);
    pulse(P_TAKEN);
    rd(ADDR_CTRL, 8'h40);
    globalIrqEnable <= 1;
    wr(ADDR_CTRL, 8'h48);
    pulse(P_RESTART);
    waitEv(1);
    rd(ADDR_CTRL, 8'h88);
    wr(ADDR_CTRL, 8'h88);
    rd(ADDR_CTRL, 8'h08);
    pulse(P_RESTART);
    waitEv(0);
    $display("done: interrupt modes");
    safetyLevelOption <= 1;
    arst_n <= 0;
    idle(4);
    arst_n <= 1;
    idle(4);
    check({32'h0, safetyLevel2}, 33'h1);
    rd(ADDR_CTRL, 8'h08);
    wr(ADDR_CTRL, 8'h18);
    wr(ADDR_CTRL, 8'h02);
    rd(ADDR_CTRL, 8'h0a);
    idle(2);
    $display("done: safety level 2");
    results();
  end
endmodule : tb_top
`default_nettype wire
